// *** common/gfel_map.svh ***
/*
  Offsets, field layout and reset values of the global error log pair.
  Assumes inclusion by bare name from any file that needs these numbers.
*/
`ifndef GFEL_MAP_SVH
`define GFEL_MAP_SVH

`define GFEL_FIRST_OFS     8'h40
`define GFEL_NEXT_OFS      8'h44
`define GFEL_LOG_RESET     32'h0000_0000
`define GFEL_IMPL_MASK     32'h0FFC_7FF0
`define GFEL_FATAL_MASK    32'h0FFC_0000
`define GFEL_NONFATAL_MASK 32'h0000_7FF0
`define GFEL_FATAL_MSB     27
`define GFEL_FATAL_LSB     18
`define GFEL_NONFATAL_MSB  14
`define GFEL_NONFATAL_LSB  4
`define GFEL_N_FATAL       10
`define GFEL_N_NONFATAL    11
`define GFEL_N_PCIE        6

`endif

// *** common/gfel_pkg.sv ***
/*
  Types shared by the global error log design files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package gfel_pkg;
  typedef logic [31:0] gfel_word_t;

  typedef enum logic [1:0] {
    GFEL_RSEL_NONE  = 2'b00,
    GFEL_RSEL_FIRST = 2'b01,
    GFEL_RSEL_NEXT  = 2'b10
  } gfel_rsel_t;
endpackage

`default_nettype wire

// *** rtl/gfel_err_map.sv ***
/*
  Places per-unit error reports on their global log bit positions.
  Assumes unit reports are single-cycle, synchronous, already unmasked.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gfel_map.svh"

module gfel_err_map
  import gfel_pkg::*;
(
  input  wire logic [`GFEL_N_FATAL-1:0]    i_fatal_err,
  input  wire logic [`GFEL_N_NONFATAL-1:0] i_unc_nf_err,
  input  wire logic [`GFEL_N_NONFATAL-1:0] i_corr_err,
  output var gfel_word_t                   o_events
);
  // correctable and uncorrectable-non-fatal fold into one class [R8]
  wire logic [`GFEL_N_NONFATAL-1:0] nonfatal_ev;
  assign nonfatal_ev = i_unc_nf_err | i_corr_err; // [R8]

  // only the unit summary lands here; detail stays in unit logs [R13]
  assign o_events = {4'h0, i_fatal_err, 3'h0, nonfatal_ev, 4'h0}; // [R9] [R10] [R11] [R12] [R15]
endmodule

`default_nettype wire

// *** rtl/gfel_top.sv ***
/*
  Global first/next error log pair with its configuration-space port.
  Assumes synchronous single-cycle config accesses and unit error pulses;
  i_srst is the ordinary reset, i_por the power-on clear of the logs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gfel_map.svh"

// Summary of operation
// [R1] Every implemented first-log bit keeps its value through the ordinary reset.
// [R2] A global bit is set for every unit-level error, independent of any signalling enable.
// [R3] The first fatal error and the first non-fatal error are captured independently.
// [R4] Once the first log holds an error of a class, later errors of it go to the next log.
// [R5] While a class field of the first log is set, no further bit of it is set until cleared.
// [R6] All errors of a class reported in the same cycle as its first one are latched together.
// [R7] Writing one clears a bit and writing zero leaves it unchanged.
// [R8] Correctable and uncorrectable non-fatal errors are both logged as non-fatal.
// [R9] Fatal bits 27..24 are DRAM channel, system bus, hub link and DMA controller.
// [R10] Fatal bits 23..18 are PCI Express ports A, A1, B, B1, C and C1.
// [R11] Non-fatal bits 14..10 are buffers, DRAM, system bus, hub link and DMA.
// [R12] Non-fatal bits 9..4 are PCI Express ports A, A1, B, B1, C and C1.
// [R13] Global bits only summarise units; detailed conditions live in unit logs.
// [R14] The next log uses the same bit layout and is also sticky through reset.
// [R15] Reserved bits 31..28, 17..15 and 3..0 read zero and ignore writes.
module gfel_top
  import gfel_pkg::*;
#(
  parameter int N_PCIE = `GFEL_N_PCIE
)(
  input  wire logic                        i_mclk,
  input  wire logic                        i_srst,
  input  wire logic                        i_por,
  input  wire logic [`GFEL_N_FATAL-1:0]    i_fatal_err,
  input  wire logic [`GFEL_N_NONFATAL-1:0] i_unc_nf_err,
  input  wire logic [`GFEL_N_NONFATAL-1:0] i_corr_err,
  input  wire logic                        i_cfg_wr,
  input  wire logic                        i_cfg_rd,
  input  wire logic [7:0]                  i_cfg_addr,
  input  wire logic [3:0]                  i_cfg_be,
  input  wire logic [31:0]                 i_cfg_wdata,
  output logic [31:0]                      o_cfg_rdata,
  output logic                             o_cfg_rvalid,
  output logic [31:0]                      o_first_log,
  output logic [31:0]                      o_next_log
);

  if (N_PCIE != `GFEL_N_PCIE) begin : g_chk
    $error("gfel_top: bit layout serves exactly six PCI Express ports");
  end

  function automatic gfel_word_t be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  gfel_word_t first_r;
  gfel_word_t first_nxt;
  gfel_word_t next_r;
  gfel_word_t next_nxt;
  gfel_word_t rdata_r;
  gfel_word_t rdata_nxt;
  logic       rvalid_r;

  gfel_word_t events;
  gfel_word_t first_set;
  gfel_word_t next_set;
  gfel_word_t clr_first;
  gfel_word_t clr_next;
  gfel_rsel_t rsel;
  wire logic  fatal_empty;
  wire logic  nonfatal_empty;
  wire logic  wr_first;
  wire logic  wr_next;

  gfel_err_map u_map (
    .i_fatal_err  (i_fatal_err),
    .i_unc_nf_err (i_unc_nf_err),
    .i_corr_err   (i_corr_err),
    .o_events     (events)
  );

  // each class gates its own field, so a fatal capture never blocks
  // a first non-fatal capture and vice versa
  assign fatal_empty    = ~|(first_r & `GFEL_FATAL_MASK);    // [R3]
  assign nonfatal_empty = ~|(first_r & `GFEL_NONFATAL_MASK); // [R3]

  // a whole cycle's worth of same-class events is taken at once [R6]
  assign first_set = (fatal_empty    ? (events & `GFEL_FATAL_MASK)    : '0)
                   | (nonfatal_empty ? (events & `GFEL_NONFATAL_MASK) : '0); // [R5] [R6]
  assign next_set  = events & ~first_set; // [R4]

  assign wr_first  = i_cfg_wr && (i_cfg_addr == `GFEL_FIRST_OFS);
  assign wr_next   = i_cfg_wr && (i_cfg_addr == `GFEL_NEXT_OFS);
  assign clr_first = wr_first ? (i_cfg_wdata & be_mask(i_cfg_be) & `GFEL_IMPL_MASK) : '0; // [R7] [R15]
  assign clr_next  = wr_next  ? (i_cfg_wdata & be_mask(i_cfg_be) & `GFEL_IMPL_MASK) : '0; // [R7] [R15]

  // set beats clear: an event in the clearing cycle is never lost
  assign first_nxt = (first_r & ~clr_first) | first_set; // [R2] [R7]
  assign next_nxt  = (next_r  & ~clr_next)  | next_set;  // [R2] [R4] [R14]

  assign rsel = !i_cfg_rd                     ? GFEL_RSEL_NONE  :
                (i_cfg_addr == `GFEL_FIRST_OFS) ? GFEL_RSEL_FIRST :
                (i_cfg_addr == `GFEL_NEXT_OFS)  ? GFEL_RSEL_NEXT  : GFEL_RSEL_NONE;

  always_comb begin
    case (rsel)
      GFEL_RSEL_FIRST: rdata_nxt = first_r & `GFEL_IMPL_MASK; // [R15]
      GFEL_RSEL_NEXT:  rdata_nxt = next_r  & `GFEL_IMPL_MASK; // [R15]
      default:         rdata_nxt = '0;
    endcase
  end

  // logs ignore i_srst on purpose so software can read them after the
  // reset that often follows a fatal error; only power-on clears them
  always_ff @(posedge i_mclk) begin
    if (i_por) begin
      first_r <= `GFEL_LOG_RESET;
      next_r  <= `GFEL_LOG_RESET;
    end else begin
      first_r <= first_nxt; // [R1]
      next_r  <= next_nxt;  // [R14]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst || i_por) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= i_cfg_rd;
    end
  end

  assign o_cfg_rdata  = rdata_r;
  assign o_cfg_rvalid = rvalid_r;
  assign o_first_log  = first_r;
  assign o_next_log   = next_r;

  // checks; all are gated only by the power-on clear, since the logs
  // must behave identically across the ordinary reset
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_por);

  wire logic quiet;
  assign quiet = ~|events && !i_cfg_wr;

  property p_sticky_srst;
    i_srst && quiet |=> (first_r == $past(first_r)) && (next_r == $past(next_r));
  endproperty
  a_sticky_srst: assert property (p_sticky_srst) // [R1] [R14]
    else $error("error log changed across ordinary reset");

  property p_event_logged;
    |events |=> (((first_r | next_r) & $past(events)) == $past(events));
  endproperty
  a_event_logged: assert property (p_event_logged) // [R2]
    else $error("reported unit error not logged next cycle");

  property p_first_fatal_all;
    fatal_empty && |(events & `GFEL_FATAL_MASK)
      |=> ((first_r & `GFEL_FATAL_MASK) == $past(events & `GFEL_FATAL_MASK));
  endproperty
  a_first_fatal_all: assert property (p_first_fatal_all) // [R6]
    else $error("first fatal capture missed a same-cycle error");

  property p_nonfatal_indep;
    !fatal_empty && nonfatal_empty && |(events & `GFEL_NONFATAL_MASK)
      |=> ((first_r & `GFEL_NONFATAL_MASK) == $past(events & `GFEL_NONFATAL_MASK));
  endproperty
  a_nonfatal_indep: assert property (p_nonfatal_indep) // [R3]
    else $error("first non-fatal capture blocked by fatal entry");

  property p_later_to_next;
    !fatal_empty && |(events & `GFEL_FATAL_MASK)
      |=> ((next_r & $past(events & `GFEL_FATAL_MASK)) == $past(events & `GFEL_FATAL_MASK));
  endproperty
  a_later_to_next: assert property (p_later_to_next) // [R4]
    else $error("later fatal error not routed to next log");

  property p_no_new_first;
    !nonfatal_empty |=> ((first_r & `GFEL_NONFATAL_MASK & ~$past(first_r)) == '0);
  endproperty
  a_no_new_first: assert property (p_no_new_first) // [R5]
    else $error("new first-log bit set while field occupied");

  property p_no_new_fatal;
    !fatal_empty |=> ((first_r & `GFEL_FATAL_MASK & ~$past(first_r)) == '0);
  endproperty
  a_no_new_fatal: assert property (p_no_new_fatal) // [R5]
    else $error("new fatal first-log bit set while field occupied");

  property p_w1c;
    wr_first && ~|events
      |=> (first_r == ($past(first_r) & ~($past(i_cfg_wdata) & be_mask($past(i_cfg_be)))));
  endproperty
  a_w1c: assert property (p_w1c) // [R7]
    else $error("write-one-to-clear misbehaved");

  property p_nonfatal_class;
    |(i_corr_err | i_unc_nf_err) |=> ((((first_r | next_r) >> `GFEL_NONFATAL_LSB) &
      32'({$past(i_corr_err | i_unc_nf_err)})) == 32'({$past(i_corr_err | i_unc_nf_err)}));
  endproperty
  a_nonfatal_class: assert property (p_nonfatal_class) // [R8] [R11] [R12]
    else $error("non-fatal unit error not at its global bit");

  property p_fatal_pos;
    |i_fatal_err |=> ((((first_r | next_r) >> `GFEL_FATAL_LSB) & 32'({$past(i_fatal_err)}))
      == 32'({$past(i_fatal_err)}));
  endproperty
  a_fatal_pos: assert property (p_fatal_pos) // [R9] [R10]
    else $error("fatal unit error not at its global bit");

  property p_reserved_zero;
    ((first_r | next_r | rdata_r) & ~`GFEL_IMPL_MASK) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R15]
    else $error("reserved log bit nonzero");

  c_first_fatal:  cover property (fatal_empty && |(events & `GFEL_FATAL_MASK));
  c_next_logged:  cover property (!fatal_empty && |(events & `GFEL_FATAL_MASK));
  c_clear_first:  cover property (wr_first && |(clr_first & first_r));
  c_both_classes: cover property (|(events & `GFEL_FATAL_MASK) && |(events & `GFEL_NONFATAL_MASK));
endmodule

`default_nettype wire

// *** tb/gfel_top_tb.sv ***
/*
  Self-checking bench for the global first/next error log pair.
  Assumes gfel_top with single-cycle config strobes and error pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gfel_map.svh"

module gfel_top_tb
  import gfel_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_por  = 1'b1;
  logic [9:0]  f_err  = '0;
  logic [10:0] u_err  = '0;
  logic [10:0] c_err  = '0;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic [7:0]  addr   = '0;
  logic [3:0]  be     = '0;
  logic [31:0] wd     = '0;
  logic [31:0] rdata, flog, nlog, m_first, m_next, m_rdata;
  logic        rvalid, m_rvalid;
  logic [31:0] rs     = 32'h9CAEC23B;
  logic        chk_en = 1'b0;
  int          n_fail = 0;
  int          n_compared = 0;

  always #2 i_mclk = ~i_mclk;

  gfel_top DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_por(i_por), .i_fatal_err(f_err),
    .i_unc_nf_err(u_err), .i_corr_err(c_err), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdata),
    .o_cfg_rvalid(rvalid), .o_first_log(flog), .o_next_log(nlog));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // reference model: class field occupancy decides first versus next log
  always @(posedge i_mclk) begin : mdl
    logic [31:0] ev, bem, cf, cn, ef;
    ev  = {4'h0, f_err, 3'h0, u_err | c_err, 4'h0};
    bem = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wd & `GFEL_IMPL_MASK;
    cf  = (wr && addr == `GFEL_FIRST_OFS) ? bem : 32'h0;
    cn  = (wr && addr == `GFEL_NEXT_OFS) ? bem : 32'h0;
    ef  = 32'h0;
    if (!(|(m_first & `GFEL_FATAL_MASK))) ef = ef | (ev & `GFEL_FATAL_MASK);
    if (!(|(m_first & `GFEL_NONFATAL_MASK))) ef = ef | (ev & `GFEL_NONFATAL_MASK);
    m_rvalid <= rd && !i_srst && !i_por;
    m_rdata  <= (!rd || i_srst || i_por) ? 32'h0 :
                (addr == `GFEL_FIRST_OFS) ? m_first :
                (addr == `GFEL_NEXT_OFS) ? m_next : 32'h0;
    if (i_por) begin
      m_first <= `GFEL_LOG_RESET;
      m_next  <= `GFEL_LOG_RESET;
    end else begin
      m_first <= (m_first & ~cf) | ef;
      m_next  <= (m_next & ~cn) | (ev & ~ef);
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  always @(negedge i_mclk) begin
    if (chk_en) begin
      chk("first_log", m_first, flog);
      chk("next_log", m_next, nlog);
      chk("rvalid", {31'h0, m_rvalid}, {31'h0, rvalid});
      chk("rdata", m_rdata, rdata);
    end
  end

  task automatic cyc(input logic [9:0] f, input logic [10:0] u, input logic [10:0] c,
                     input logic w, input logic r, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(posedge i_mclk);
    f_err <= f; u_err <= u; c_err <= c;
    wr <= w; rd <= r; addr <= a; be <= b; wd <= d;
  endtask

  task automatic idle();
    cyc('0, '0, '0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
  endtask

  task automatic clr_all();
    cyc('0, '0, '0, 1'b1, 1'b0, `GFEL_FIRST_OFS, 4'hF, 32'hFFFFFFFF);
    cyc('0, '0, '0, 1'b1, 1'b1, `GFEL_NEXT_OFS, 4'hF, 32'hFFFFFFFF);
    idle();
  endtask

  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_mclk);
    i_por <= 1'b0;
    i_srst <= 1'b0;
    @(posedge i_mclk);
    chk_en <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      clr_all();
      if (i < 10) begin
        cyc(10'h1 << i, '0, '0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
        idle();
        // logs only settle after the edge that takes the event
        @(negedge i_mclk);
        chk("fatal_pos", 32'h1 << (18 + i), flog);
      end
      cyc('0, 11'h1 << i, '0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
      cyc('0, '0, 11'h1 << i, 1'b0, 1'b1, `GFEL_NEXT_OFS, 4'h0, 32'h0);
      idle();
      @(negedge i_mclk);
      chk("nonfatal_pos", 32'h1 << (4 + i), flog & `GFEL_NONFATAL_MASK);
      chk("nonfatal_next", 32'h1 << (4 + i), nlog & `GFEL_NONFATAL_MASK);
    end
    // same-cycle burst, then a second burst that must go to the next log
    clr_all();
    cyc(10'h3FF, 11'h7FF, '0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
    cyc(10'h021, 11'h400, '0, 1'b0, 1'b1, `GFEL_FIRST_OFS, 4'h0, 32'h0);
    idle();
    chk("burst", `GFEL_IMPL_MASK, flog);
    // zero data, no lanes, partial lane, reserved bits, unmapped place
    cyc('0, '0, '0, 1'b1, 1'b0, `GFEL_FIRST_OFS, 4'hF, 32'h0);
    cyc('0, '0, '0, 1'b1, 1'b0, `GFEL_FIRST_OFS, 4'h0, 32'hFFFFFFFF);
    cyc('0, '0, '0, 1'b1, 1'b1, `GFEL_FIRST_OFS, 4'h8, 32'hFFFFFFFF);
    cyc('0, '0, '0, 1'b1, 1'b1, 8'h48, 4'hF, 32'hFFFFFFFF);
    // ordinary reset mid-run keeps both logs and keeps logging
    cyc(10'h004, '0, '0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
    i_srst <= 1'b1;
    // quiet cycles in between so the logs are seen holding still under reset
    for (int k = 0; k < 8; k++) begin
      cyc('0, k[0] ? 11'h002 : 11'h0, '0, 1'b0, 1'b1, `GFEL_FIRST_OFS, 4'h0, 32'h0);
    end
    i_srst <= 1'b0;
    for (int n = 0; n < 3000; n++) begin
      logic [31:0] a, b, c;
      a = lfsr(rs);
      b = lfsr(a);
      c = lfsr(b);
      rs = c;
      cyc((a[3:0] == 4'h0) ? a[13:4] : 10'h0, (b[3:0] == 4'h0) ? b[14:4] : 11'h0,
          (c[3:0] == 4'h0) ? c[14:4] : 11'h0, a[20:18] == 3'h0, a[21],
          a[22] ? `GFEL_FIRST_OFS : (a[23] ? `GFEL_NEXT_OFS : 8'h4C), b[19:16], c);
    end
    idle();
    idle();
    stop_test();
  end
endmodule

`default_nettype wire
